/* File: rtl/cssc_pkg.sv */
// Package for the CPU stack and sleep control block
// Assumes an 8-bit core with on-chip register RAM of 128 or 256 bytes
package cssc_pkg;
    // ==================================================
    // Widths and sizes
    localparam int          PTR_W       = 8;
    localparam int          DATA_W      = 8;
    localparam int          RAM_BYTES   = 256;
    localparam logic [7:0]  PTR_RESET   = 8'h00;
    localparam logic [7:0]  PTR_ONE     = 8'h01;
    // ==================================================
    // Stack request codes
    typedef enum logic [2:0] {
        CSSC_OP_NONE,
        CSSC_OP_PUSH,
        CSSC_OP_POP,
        CSSC_OP_LOAD,
        CSSC_OP_ALU
    } cssc_op_e;
    // ==================================================
    // Two-register ALU operations
    typedef enum logic [2:0] {
        CSSC_ALU_ADD,
        CSSC_ALU_SUB,
        CSSC_ALU_AND,
        CSSC_ALU_OR,
        CSSC_ALU_XOR,
        CSSC_ALU_MOV
    } cssc_alu_e;
    // ==================================================
    // Power states
    typedef enum logic [1:0] {
        CSSC_RUN,
        CSSC_STANDBY,
        CSSC_FULLSTOP
    } cssc_pwr_e;
endpackage : cssc_pkg

/* File: rtl/cssc_core.sv */
// Stack pointer, register RAM, two-register ALU and low-power control
// Assumes the sequencer issues one request per cycle and holds none
//
// Operation
// - Eight-bit pointer selects one RAM byte
// - Push increments pointer, then writes byte
// - Pop reads byte, then decrements pointer
// - Pointer holds most recent pushed byte
// - Stack anywhere in 128/256-byte RAM
// - Stack saves return addresses and flags
// - No instruction execution in low power
// - Standby keeps oscillator and timer running
// - Full stop halts oscillator and peripherals
// - RAM and configuration survive low power
// - ALU combines two registers (MOV copies the first), writes second
`timescale 1ns/1ps
`default_nettype none
module cssc_core
    import cssc_pkg::*;
#(
    parameter int RAM_SIZE = RAM_BYTES
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Sequencer requests
    input  wire logic [2:0]         opCode,
    input  wire logic [7:0]         opData,
    input  wire logic [2:0]         aluSel,
    input  wire logic [7:0]         srcAddr,
    input  wire logic [7:0]         dstAddr,
    // Power requests
    input  wire logic               enterStandby,
    input  wire logic               enterFullStop,
    input  wire logic               wakeEvent,
    // Results
    output logic [7:0]              stack_top_pointer,
    output logic [7:0]              popData,
    output logic                    popValid,
    output logic [7:0]              aluResult,
    output logic                    aluValid,
    // Power control
    output logic                    execEnable,
    output logic                    oscEnable,
    output logic                    timerEnable,
    output logic                    periphEnable
);
    // ==================================================
    // Storage
    logic [7:0]  regRam [RAM_SIZE];
    cssc_pwr_e   pwrState;
    logic        active;
    logic [7:0]  next_sp;
    logic [7:0]  srcVal;
    logic [7:0]  dstVal;
    logic [7:0]  next_alu;

    // Pointer arithmetic wraps naturally at 8 bits
    function automatic logic [7:0] stepPtr(input logic [7:0] p, input logic up);
        stepPtr = up ? p + PTR_ONE : p - PTR_ONE;
    endfunction

    // Index into RAM, folded to the fitted size
    function automatic int ramIdx(input logic [7:0] a);
        ramIdx = int'(a) % RAM_SIZE;
    endfunction

    // A request is taken only while the core runs; in sleep it is dropped
    function automatic logic takenOp(input logic run, input logic [2:0] code,
                                     input cssc_op_e op);
        takenOp = run && (cssc_op_e'(code) == op);
    endfunction

    assign active = (pwrState == CSSC_RUN);
    assign srcVal = regRam[ramIdx(srcAddr)];
    assign dstVal = regRam[ramIdx(dstAddr)];

    // ==================================================
    // Next pointer value
    always_comb begin
        next_sp = stack_top_pointer;
        if (active) begin
            case (cssc_op_e'(opCode))
                CSSC_OP_PUSH: next_sp = stepPtr(stack_top_pointer, 1'b1);
                CSSC_OP_POP:  next_sp = stepPtr(stack_top_pointer, 1'b0);
                CSSC_OP_LOAD: next_sp = opData;
                default:      next_sp = stack_top_pointer;
            endcase
        end
    end

    // Stack pointer register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stack_top_pointer <= PTR_RESET;
        end else begin
            stack_top_pointer <= next_sp;
        end
    end

    // ALU combines both registers with no accumulator, except MOV, which copies the source
    always_comb begin
        case (cssc_alu_e'(aluSel))
            CSSC_ALU_ADD: next_alu = dstVal + srcVal;
            CSSC_ALU_SUB: next_alu = dstVal - srcVal;
            CSSC_ALU_AND: next_alu = dstVal & srcVal;
            CSSC_ALU_OR:  next_alu = dstVal | srcVal;
            CSSC_ALU_XOR: next_alu = dstVal ^ srcVal;
            CSSC_ALU_MOV: next_alu = srcVal;
            default:      next_alu = dstVal;
        endcase
    end

    // RAM writes: push at incremented pointer, ALU into second register
    always_ff @(posedge ref_clk) begin
        if (takenOp(active, opCode, CSSC_OP_PUSH)) begin
            regRam[ramIdx(next_sp)] <= opData;
        end else if (takenOp(active, opCode, CSSC_OP_ALU)) begin
            regRam[ramIdx(dstAddr)] <= next_alu;
        end
    end

    // Pop reads at current pointer before decrement
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            popData  <= 8'h00;
            popValid <= 1'b0;
        end else begin
            popValid <= takenOp(active, opCode, CSSC_OP_POP);
            if (takenOp(active, opCode, CSSC_OP_POP)) begin
                popData <= regRam[ramIdx(stack_top_pointer)];
            end
        end
    end

    // ALU result register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aluResult <= 8'h00;
            aluValid  <= 1'b0;
        end else begin
            aluValid <= takenOp(active, opCode, CSSC_OP_ALU);
            if (takenOp(active, opCode, CSSC_OP_ALU)) begin
                aluResult <= next_alu;
            end
        end
    end

    // ==================================================
    // Power state machine; RAM and pointer are never cleared here
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pwrState <= CSSC_RUN;
        end else begin
            case (pwrState)
                CSSC_RUN: begin
                    if (enterFullStop) begin
                        pwrState <= CSSC_FULLSTOP;
                    end else if (enterStandby) begin
                        pwrState <= CSSC_STANDBY;
                    end
                end
                CSSC_STANDBY, CSSC_FULLSTOP: begin
                    if (wakeEvent) begin
                        pwrState <= CSSC_RUN;
                    end
                end
                default: pwrState <= CSSC_RUN;
            endcase
        end
    end

    // Enables follow the power state
    always_comb begin
        execEnable   = active;
        oscEnable    = pwrState != CSSC_FULLSTOP;
        timerEnable  = pwrState != CSSC_FULLSTOP;
        periphEnable = active;
    end

    // ==================================================
    // Checks
    a_push_increments: assert property (@(posedge ref_clk) disable iff (rst)
        active && opCode == 3'(CSSC_OP_PUSH)
        |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
        else $error("push did not increment pointer");
    a_pop_decrements: assert property (@(posedge ref_clk) disable iff (rst)
        active && opCode == 3'(CSSC_OP_POP)
        |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01)
        else $error("pop did not decrement pointer");
    a_push_pop_return: assert property (@(posedge ref_clk) disable iff (rst)
        active && opCode == 3'(CSSC_OP_PUSH) ##1 active && opCode == 3'(CSSC_OP_POP)
        |=> popData == $past(opData, 2) && popValid)
        else $error("popped byte differs from pushed byte");
    a_sleep_holds_sp: assert property (@(posedge ref_clk) disable iff (rst)
        !active |=> stack_top_pointer == $past(stack_top_pointer))
        else $error("pointer changed in low power");
    a_sleep_no_exec: assert property (@(posedge ref_clk) disable iff (rst)
        !active |=> !popValid && !aluValid)
        else $error("execution during low power");
    a_standby_clocks: assert property (@(posedge ref_clk) disable iff (rst)
        pwrState == CSSC_STANDBY |-> oscEnable && timerEnable && !execEnable)
        else $error("standby clock enables wrong");
    a_stop_all: assert property (@(posedge ref_clk) disable iff (rst)
        pwrState == CSSC_FULLSTOP |-> !oscEnable && !timerEnable && !periphEnable)
        else $error("full stop left activity on");
    a_wrap_top: assert property (@(posedge ref_clk) disable iff (rst)
        active && opCode == 3'(CSSC_OP_PUSH) && stack_top_pointer == 8'hff
        |=> stack_top_pointer == 8'h00)
        else $error("pointer did not wrap");
    a_wrap_bottom: assert property (@(posedge ref_clk) disable iff (rst)
        active && opCode == 3'(CSSC_OP_POP) && stack_top_pointer == 8'h00
        |=> stack_top_pointer == 8'hff)
        else $error("pointer did not wrap below zero");
    a_alu_add: assert property (@(posedge ref_clk) disable iff (rst)
        active && opCode == 3'(CSSC_OP_ALU) && aluSel == 3'(CSSC_ALU_ADD)
        |=> aluValid && aluResult == $past(dstVal) + $past(srcVal))
        else $error("add result wrong");
    c_push_pop: cover property (@(posedge ref_clk)
        opCode == 3'(CSSC_OP_PUSH) ##1 opCode == 3'(CSSC_OP_POP));
    c_standby_wake: cover property (@(posedge ref_clk)
        pwrState == CSSC_STANDBY ##[1:20] pwrState == CSSC_RUN);
    c_fullstop: cover property (@(posedge ref_clk) pwrState == CSSC_FULLSTOP);
    c_wrap: cover property (@(posedge ref_clk)
        stack_top_pointer == 8'hff ##1 stack_top_pointer == 8'h00);
endmodule // cssc_core
`default_nettype wire

/* File: sim/cssc_seq_model.sv */
// Instruction sequencer model driving the stack and sleep control block
// Assumes callers enter its tasks one clock edge plus 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module cssc_seq_model
    import cssc_pkg::*;
(
    // Clock
    input  wire logic       ref_clk,
    // Requests towards the block
    output var  logic [2:0] opCode,
    output var  logic [7:0] opData,
    output var  logic [2:0] aluSel,
    output var  logic [7:0] srcAddr,
    output var  logic [7:0] dstAddr,
    output var  logic       enterStandby,
    output var  logic       enterFullStop,
    output var  logic       wakeEvent
);
    // ==================================================
    // Idle values at time zero
    initial begin
        {opCode, opData, aluSel, srcAddr, dstAddr} = '0;
        {enterStandby, enterFullStop, wakeEvent} = '0;
    end
    // One request held for one edge; left standing for back-to-back use
    task automatic req(input logic [2:0] op, input logic [7:0] d,
                       input logic [2:0] sel, input logic [7:0] s, input logic [7:0] t);
        opCode  = op;
        opData  = d;
        aluSel  = sel;
        srcAddr = s;
        dstAddr = t;
        @(posedge ref_clk);
        #1;
    endtask
    // Power request pulse of one cycle, stack idle meanwhile
    task automatic pwr(input logic sb, input logic fs, input logic wk);
        opCode        = 3'h0;
        enterStandby  = sb;
        enterFullStop = fs;
        wakeEvent     = wk;
        @(posedge ref_clk);
        #1;
        {enterStandby, enterFullStop, wakeEvent} = '0;
    endtask
endmodule // cssc_seq_model
`default_nettype wire

/* File: sim/test_cpu_stack_and_sleep_control.sv */
// Self-checking bench: stack pushes and pops, two-register ALU, sleep modes
// Assumes the sequencer model drives every request input
`timescale 1ns/1ps
`default_nettype none
module test_cpu_stack_and_sleep_control
    import cssc_pkg::*;
;
    // ==================================================
    // Signals and reference model state
    logic       ref_clk = 1'b0;
    logic       rst     = 1'b1;
    logic [2:0] opCode, aluSel;
    logic [7:0] opData, srcAddr, dstAddr, sp, popData, aluResult, a, b, r;
    logic       enterStandby, enterFullStop, wakeEvent, popValid, aluValid;
    logic       execEnable, oscEnable, timerEnable, periphEnable;
    logic [7:0] mem [256];
    logic [7:0] spM;
    int         failures = 0, n_tests = 0, cyc = 0;
    always #2.5 ref_clk = ~ref_clk;
    cssc_seq_model u_seq (.ref_clk(ref_clk), .opCode(opCode), .opData(opData),
        .aluSel(aluSel), .srcAddr(srcAddr), .dstAddr(dstAddr), .enterStandby(enterStandby),
        .enterFullStop(enterFullStop), .wakeEvent(wakeEvent));
    cssc_core u_dut (.ref_clk(ref_clk), .rst(rst), .opCode(opCode), .opData(opData),
        .aluSel(aluSel), .srcAddr(srcAddr), .dstAddr(dstAddr), .enterStandby(enterStandby),
        .enterFullStop(enterFullStop), .wakeEvent(wakeEvent), .stack_top_pointer(sp),
        .popData(popData), .popValid(popValid), .aluResult(aluResult), .aluValid(aluValid),
        .execEnable(execEnable), .oscEnable(oscEnable), .timerEnable(timerEnable),
        .periphEnable(periphEnable));
    // ==================================================
    // Comparison, verdict and hang guard
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp || $isunknown(seen)) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            give_verdict();
        end
    end
    // Push and pop through the model with expectations from the reference
    task automatic push(input logic [7:0] d);
        u_seq.req(3'h1, d, 3'h0, 8'h00, 8'h00);
        spM = spM + 8'h01;
        mem[spM] = d;
        chk("push pointer", sp, spM);
    endtask
    task automatic pop();
        u_seq.req(3'h2, 8'h00, 3'h0, 8'h00, 8'h00);
        chk("pop data", popData, mem[spM]);
        chk("pop valid", {7'h00, popValid}, 8'h01);
        spM = spM - 8'h01;
        chk("pop pointer", sp, spM);
    endtask
    task automatic pwrChk(input logic [3:0] exp);
        chk("power enables", {4'h0, execEnable, oscEnable, timerEnable, periphEnable},
            {4'h0, exp});
    endtask
    // ==================================================
    // Main sequence
    initial begin
        void'($urandom(98663));
        repeat (3) @(posedge ref_clk);
        #1 rst = 1'b0;
        chk("reset pointer", sp, PTR_RESET);
        chk("reset alu", aluResult, 8'h00);
        pwrChk(4'hf);
        // Wrap past the top and back below zero
        spM = 8'hfd;
        u_seq.req(3'h3, spM, 3'h0, 8'h00, 8'h00);
        chk("load pointer", sp, spM);
        repeat (6) push(8'($urandom));
        repeat (4) pop();
        repeat (2) pop();
        // Every ALU operation; result lands in the second register
        for (int k = 0; k < 6; k++) begin
            spM = 8'h0f + 8'(k * 2);
            u_seq.req(3'h3, spM, 3'h0, 8'h00, 8'h00);
            a = 8'($urandom);
            b = 8'($urandom);
            push(a);
            push(b);
            case (k)
                0: r = b + a;
                1: r = b - a;
                2: r = b & a;
                3: r = b | a;
                4: r = b ^ a;
                default: r = a;
            endcase
            u_seq.req(3'h4, 8'h00, 3'(k), spM - 8'h01, spM);
            chk("alu result", aluResult, r);
            chk("alu valid", {7'h00, aluValid}, 8'h01);
            mem[spM] = r;
            pop();
        end
        // Standby: processor stopped, oscillator and timer alive, push refused
        u_seq.pwr(1'b1, 1'b0, 1'b0);
        pwrChk(4'b0110);
        u_seq.req(3'h1, 8'h5a, 3'h0, 8'h00, 8'h00);
        chk("standby push", sp, spM);
        u_seq.pwr(1'b0, 1'b0, 1'b1);
        pwrChk(4'hf);
        // One idle edge so the power strobes are not driven twice in one step
        u_seq.req(3'h0, 8'h00, 3'h0, 8'h00, 8'h00);
        // Full stop, with standby asked at once: full stop wins
        u_seq.pwr(1'b1, 1'b1, 1'b0);
        pwrChk(4'b0000);
        u_seq.req(3'h2, 8'h00, 3'h0, 8'h00, 8'h00);
        chk("halt pop", sp, spM);
        chk("halt pop valid", {7'h00, popValid}, 8'h00);
        u_seq.pwr(1'b0, 1'b0, 1'b1);
        pwrChk(4'hf);
        // Contents kept across both sleeps
        repeat (3) pop();
        // Mid-run reset wins over the pop still standing on the request lines
        rst = 1'b1;
        @(posedge ref_clk);
        #1 rst = 1'b0;
        chk("reset again pointer", sp, PTR_RESET);
        chk("reset again pop valid", {7'h00, popValid}, 8'h00);
        give_verdict();
    end
endmodule // test_cpu_stack_and_sleep_control
`default_nettype wire
